//--- bench/adc_serial_port_and_timer_load_tb.sv
// bench: host registers, link and converter end
`timescale 1ns/1ps
module adc_serial_port_and_timer_load_tb;
    import asp_pkg::*;
    // osc cycles per phase at preset FF
    localparam int PH_OSC = (256 - 255) * 256 * 4;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rv;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rr, channel_sel;
    logic        osc_clk, reset_hi, zero_cross, input_negative;
    asp_phase_e  phase, ph_prev;
    int          ph_run, errors, check_count;
    int          ph_len [4];
    logic [7:0]  wr_bits;
    logic [19:0] rd_bits;

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    // oscillator, unrelated in phase
    initial begin
        osc_clk = 1'b0;
        #1.3;
        forever #62.5 osc_clk = ~osc_clk;
    end

    asp_link_if asp_link_if_i ();
    asp_host asp_host_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .link(asp_link_if_i));
    asp_device asp_device_i (.link(asp_link_if_i), .osc_clk(osc_clk), .reset_hi(reset_hi),
        .zero_cross(zero_cross), .input_negative(input_negative), .channel_sel(channel_sel), .phase(phase));
    asp_link_props asp_link_props_i (.aclk(aclk), .aresetn(aresetn), .dclk(asp_link_if_i.dclk),
        .din(asp_link_if_i.din), .dout(asp_link_if_i.dout), .rw(asp_link_if_i.rw), .eoc_n(asp_link_if_i.eoc_n));

    // link bits as each end samples them
    always @(posedge asp_link_if_i.dclk) begin
        if (!asp_link_if_i.rw) wr_bits <= {wr_bits[6:0], asp_link_if_i.din};
        else rd_bits <= {rd_bits[18:0], asp_link_if_i.dout};
    end
    // last run length of each phase, osc cycles
    always @(posedge osc_clk) begin
        if (phase !== ph_prev) begin
            ph_len[ph_prev] <= ph_run;
            ph_run <= 1;
        end else begin
            ph_run <= ph_run + 1;
        end
        ph_prev <= phase;
    end

    task automatic wrap_up;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic give_up;
        errors++;
        $display("mismatch %0t: got %h exp %h", $time, 1'b0, 1'b1);
        wrap_up();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        check_count++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            errors++;
            $display("mismatch %0t: got %h exp %h to %h", $time, got, lo, hi);
        end
    endtask

    // one write; ready looked at mid-cycle
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, done;
        done = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int n = 0; n < 100 && !done; n++) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            done = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (!done) give_up();
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, done;
        done = 1'b0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int n = 0; n < 100 && !done; n++) begin
            @(negedge aclk);
            ta = arvalid && arready;
            done = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (!done) give_up();
    endtask
    // poll busy until the link is idle
    task automatic wait_idle;
        logic [31:0] s;
        logic [1:0]  r;
        repeat (4) @(posedge aclk);
        for (int n = 0; n < 300; n++) begin
            axi_read(ASP_REG_STATUS, s, r);
            if (s[0] === 1'b0) return;
        end
        give_up();
    endtask
    task automatic wait_phase(input asp_phase_e p, input int lim);
        for (int n = 0; n < lim; n++) begin
            @(posedge osc_clk);
            if (phase === p) return;
        end
        give_up();
    endtask

    // reset values, read-back, unmapped
    task automatic t_regs;
        axi_read(ASP_REG_CTRL, rv, rr);
        chk(rv, 32'h0);
        axi_read(ASP_REG_STATUS, rv, rr);
        chk({30'h0, rv[1:0]}, 32'h0);
        chk({30'h0, phase}, {30'h0, ASP_AUTO_ZERO_PHASE});
        axi_write(ASP_REG_PRESET, 32'hB4, rr);
        chk({30'h0, rr}, {30'h0, ASP_RESP_OKAY});
        axi_read(ASP_REG_PRESET, rv, rr);
        chk({24'h0, rv[7:0]}, 32'hB4);
        axi_read(8'h10, rv, rr);
        chk({rv[29:0], rr}, {30'h0, ASP_RESP_SLVERR});
        axi_write(8'h14, 32'hF, rr);
        chk({30'h0, rr}, {30'h0, ASP_RESP_SLVERR});
        axi_read(ASP_REG_CTRL, rv, rr);
        chk(rv, 32'h0);
    endtask
    // each channel code reaches pins and mux
    task automatic t_channel;
        for (int c = 0; c < 4; c++) begin
            axi_write(ASP_REG_CTRL, c << ASP_CTRL_CH_LO, rr);
            repeat (2) @(posedge aclk);
            chk({30'h0, channel_sel}, c);
            chk({30'h0, asp_link_if_i.channel_select_msb, asp_link_if_i.channel_select_lsb}, c);
            axi_read(ASP_REG_CTRL, rv, rr);
            chk({28'h0, rv[3:2], 2'h0}, c << ASP_CTRL_CH_LO);
        end
    endtask
    // preset bit order; mid-run reset back to auto-zero
    task automatic t_load;
        axi_write(ASP_REG_CTRL, 32'h1 << ASP_CTRL_WRITE, rr);
        wait_idle();
        chk({24'h0, wr_bits}, 32'hB4);
        wait_phase(ASP_INTEGRATE, 10);
        repeat (2) @(posedge osc_clk);
        chk({30'h0, asp_link_if_i.eoc_n, asp_link_if_i.dout}, 32'h3);
        @(posedge aclk);
        reset_hi <= 1'b1;
        repeat (8) @(posedge osc_clk);
        @(posedge aclk);
        reset_hi <= 1'b0;
        repeat (4) @(posedge osc_clk);
        chk({30'h0, phase}, {30'h0, ASP_AUTO_ZERO_PHASE});
        chk({30'h0, asp_link_if_i.eoc_n, asp_link_if_i.dout}, 32'h0);
    endtask
    // negative conversion, then result read
    task automatic t_convert;
        axi_write(ASP_REG_PRESET, 32'hFF, rr);
        axi_write(ASP_REG_CTRL, 32'h1 << ASP_CTRL_WRITE, rr);
        wait_idle();
        wait_phase(ASP_DEINTEGRATE, 1200);
        repeat (160) @(posedge osc_clk);
        @(posedge aclk);
        zero_cross <= 1'b1;
        wait_phase(ASP_AUTO_ZERO_PHASE, 100);
        @(posedge aclk);
        zero_cross <= 1'b0;
        chk_rng(ph_len[ASP_INTEGRATE], PH_OSC - 4, PH_OSC + 4);
        axi_write(ASP_REG_CTRL, 32'h1 << ASP_CTRL_READ, rr);
        wait_idle();
        axi_read(ASP_REG_RESULT, rv, rr);
        chk({rv[31:17], 17'h0}, 32'h20000);
        chk_rng({15'h0, rv[16:0]}, 38, 44);
        chk({12'h0, rd_bits}, rv);
        wait_phase(ASP_INTEGRATE, 1200);
        @(posedge osc_clk);
        chk_rng(ph_len[ASP_AUTO_ZERO_PHASE], PH_OSC - 4, PH_OSC + 4);
    endtask

    initial begin
        aresetn = 1'b0;
        reset_hi = 1'b1;
        zero_cross = 1'b0;
        input_negative = 1'b1;
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hF;
        errors = 0;
        check_count = 0;
        ph_prev = ASP_AUTO_ZERO_PHASE;
        ph_run = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8) @(posedge osc_clk);
        @(posedge aclk);
        reset_hi <= 1'b0;
        repeat (4) @(posedge osc_clk);
        t_regs();
        t_channel();
        t_load();
        t_convert();
        wrap_up();
    end
endmodule // adc_serial_port_and_timer_load_tb

//--- bench/asp_link_props.sv
// link assertions, sampled on the bus clock
`timescale 1ns/1ps
module asp_link_props (
    // bus clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link wires
    input wire logic dclk,
    input wire logic din,
    input wire logic dout,
    input wire logic rw,
    input wire logic eoc_n
);
    import asp_pkg::*;

    logic       dclk_q;
    logic       armed;
    logic [3:0] wr_rises;
    logic [4:0] rd_falls;
    logic [5:0] low_cnt;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // edge counters; armed after a first write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dclk_q   <= 1'b0;
            armed    <= 1'b0;
            wr_rises <= 4'h0;
            rd_falls <= 5'h00;
            low_cnt  <= 6'h00;
        end else begin
            dclk_q <= dclk;
            if (!rw) armed <= 1'b1;
            if (rw) wr_rises <= 4'h0;
            else if (dclk && !dclk_q) wr_rises <= wr_rises + 4'h1;
            if (!rw) rd_falls <= 5'h00;
            else if (!dclk && dclk_q) rd_falls <= (rd_falls == 5'h13) ? 5'h00 : rd_falls + 5'h01;
            low_cnt <= dclk ? 6'h00 : ((low_cnt == 6'h3F) ? low_cnt : low_cnt + 6'h01);
        end
    end

    sequence s_high_half;
        dclk [*8] ##1 !dclk;
    endsequence

    sequence s_write_tail;
        (!dclk && !rw) [*8] ##1 rw;
    endsequence

    a_din_held_high: assert property ($rose(dclk) && !rw |-> $stable(din) [*8])
        else $error("data-in moved, link clock high");
    a_din_on_fall: assert property (!rw && !$past(rw) && $changed(din) |-> $fell(dclk))
        else $error("data-in moved off a falling edge");
    a_dout_on_fall: assert property (armed && rw && $past(rw) && $changed(dout) && $stable(eoc_n) |-> $fell(dclk))
        else $error("data-out moved off a falling edge");
    a_clk_half_len: assert property ($rose(dclk) |-> s_high_half)
        else $error("link clock high not eight cycles");
    a_rw_steady_high: assert property (dclk |-> $stable(rw))
        else $error("direction moved, link clock high");
    a_frame_whole: assert property (armed && rw && low_cnt == 6'h20 |-> rd_falls == 5'h00)
        else $error("read frame not twenty bits");
    a_poll_eoc: assert property (armed && rw && low_cnt > 6'h10 |-> dout == eoc_n)
        else $error("idle data-out not eoc");
    a_write_eoc_low: assert property ($fell(rw) |-> !eoc_n)
        else $error("write begun outside auto-zero");
    a_write_eight: assert property ($rose(rw) |-> wr_rises == 4'h8)
        else $error("write did not carry eight bits");
    a_write_tail: assert property (!rw && wr_rises == 4'h8 && $fell(dclk) |-> s_write_tail)
        else $error("direction not raised after last bit");
endmodule // asp_link_props

//--- rtl/asp_device.sv
// converter end: serial port, preset load, phase sequencer
`timescale 1ns/1ps
module asp_device (
    // link to host
    asp_link_if.device       link,
    // oscillator and power-up reset
    input  wire logic        osc_clk,
    input  wire logic        reset_hi,
    // analog comparator levels
    input  wire logic        zero_cross,
    input  wire logic        input_negative,
    // analog control
    output logic [1:0]       channel_sel,
    output asp_pkg::asp_phase_e phase
);
    import asp_pkg::*;

    // oscillator domain state
    typedef struct packed {
        logic [1:0]              rst_sync;
        logic [1:0]              rw_sync;
        logic                    rw_prev;
        logic [1:0]              zc_sync;
        logic [1:0]              neg_sync;
        logic [1:0]              div;
        asp_phase_e              phase;
        logic [16:0]             cnt;
        logic                    loaded;
        logic [ASP_PRESET_W-1:0] preset;
        logic [ASP_MAG_W-1:0]    mag;
        logic                    overrange_bit;
        logic                    sign;
        logic                    eoc_n;
    } asp_dev_osc_s;

    // link rising-edge state
    typedef struct packed {
        logic [1:0]              rst_sync;
        logic [ASP_PRESET_W-1:0] shin;
    } asp_dev_rise_s;

    // link falling-edge state
    typedef struct packed {
        logic [1:0]              rst_sync;
        logic [4:0]              idx;
        logic [ASP_FRAME_W-2:0]  snap;
    } asp_dev_fall_s;

    asp_dev_osc_s  r;
    asp_dev_osc_s  next_r;
    asp_dev_rise_s q;
    asp_dev_rise_s next_q;
    asp_dev_fall_s f;
    asp_dev_fall_s next_f;
    logic          tick;
    logic          rw_rise;
    logic [16:0]   az_start;

    // channel lines go straight to the mux
    assign channel_sel = {link.channel_select_msb, link.channel_select_lsb};
    assign phase       = r.phase;
    assign link.eoc_n  = r.eoc_n;

    // data-out: eoc before clocking, then the shifter
    always_comb begin
        if (!link.rw) begin
            link.dout = 1'b0;
        end else if (f.idx == 5'h00) begin
            link.dout = r.eoc_n;
        end else begin
            link.dout = f.snap[ASP_FRAME_W-2];
        end
    end

    // timebase tick and preset load strobe
    assign tick     = (r.div == ASP_OSC_DIV_LAST);
    assign rw_rise  = r.rw_sync[1] & ~r.rw_prev;
    assign az_start = {1'b0, r.preset, ASP_CNT_LOW};

    // phase sequencer, oscillator domain
    always_comb begin
        next_r          = r;
        next_r.rst_sync = {r.rst_sync[0], reset_hi};
        next_r.rw_sync  = {r.rw_sync[0], link.rw};
        next_r.rw_prev  = r.rw_sync[1];
        next_r.zc_sync  = {r.zc_sync[0], zero_cross};
        next_r.neg_sync = {r.neg_sync[0], input_negative};
        next_r.div      = r.div + 2'h1;
        if (rw_rise) begin
            // shifter is quiet: the host stopped the link clock before raising rw
            next_r.preset = q.shin;
            next_r.loaded = 1'b1;
            next_r.phase  = ASP_INTEGRATE;
            next_r.cnt    = {1'b0, q.shin, ASP_CNT_LOW};
        end else if (tick) begin
            unique case (r.phase)
                ASP_AUTO_ZERO_PHASE: begin
                    // without a preset the converter waits in auto-zero
                    if (r.loaded) begin
                        if (r.cnt == ASP_CNT_END) begin
                            next_r.phase = ASP_INTEGRATE;
                            next_r.cnt   = az_start;
                        end else begin
                            next_r.cnt = r.cnt + 17'h00001;
                        end
                    end
                end
                ASP_INTEGRATE: begin
                    if (r.cnt == ASP_CNT_END) begin
                        next_r.sign  = r.neg_sync[1];
                        next_r.phase = ASP_DEINTEGRATE;
                        next_r.cnt   = '0;
                    end else begin
                        next_r.cnt = r.cnt + 17'h00001;
                    end
                end
                ASP_DEINTEGRATE: begin
                    // magnitude is the de-integrate count, same width
                    if (r.zc_sync[1]) begin
                        next_r.mag   = r.cnt;
                        next_r.overrange_bit   = 1'b0;
                        next_r.phase = ASP_INT_ZERO;
                        next_r.cnt   = '0;
                    end else if (r.cnt == ASP_DEINT_MAX) begin
                        next_r.mag   = r.cnt;
                        next_r.overrange_bit   = 1'b1;
                        next_r.phase = ASP_INT_ZERO;
                        next_r.cnt   = '0;
                    end else begin
                        next_r.cnt = r.cnt + 17'h00001;
                    end
                end
                ASP_INT_ZERO: begin
                    if (r.cnt == ASP_IZ_LAST) begin
                        next_r.phase = ASP_AUTO_ZERO_PHASE;
                        next_r.cnt   = az_start;
                    end else begin
                        next_r.cnt = r.cnt + 17'h00001;
                    end
                end
            endcase
        end
        // held reset forces auto-zero and forgets the preset
        if (r.rst_sync[1]) begin
            next_r.phase  = ASP_AUTO_ZERO_PHASE;
            next_r.loaded = 1'b0;
            next_r.cnt    = '0;
            next_r.div    = '0;
            next_r.mag    = '0;
            next_r.overrange_bit    = 1'b0;
            next_r.sign   = 1'b0;
            next_r.preset = '0;
        end
        // eoc low through auto-zero, when writes are safe
        next_r.eoc_n = (next_r.phase != ASP_AUTO_ZERO_PHASE);
    end

    always_ff @(posedge osc_clk) begin
        r <= next_r;
    end

    // input shifter on the link rising edge
    always_comb begin
        next_q          = q;
        next_q.rst_sync = {q.rst_sync[0], reset_hi};
        if (q.rst_sync[1]) begin
            next_q.shin = '0;
        end else if (!link.rw) begin
            next_q.shin = {q.shin[ASP_PRESET_W-2:0], link.din};
        end
    end

    always_ff @(posedge link.dclk) begin
        q <= next_q;
    end

    // output shifter on the link falling edge
    always_comb begin
        next_f          = f;
        next_f.rst_sync = {f.rst_sync[0], reset_hi};
        if (f.rst_sync[1] || !link.rw) begin
            next_f.idx  = '0;
            next_f.snap = '0;
        end else begin
            // result steady except at integrate and de-integrate ends: one grab is safe
            if (f.idx == 5'h00) begin
                next_f.snap = {r.overrange_bit, r.sign, r.mag};
            end else begin
                next_f.snap = {f.snap[ASP_FRAME_W-3:0], 1'b0};
            end
            next_f.idx = (f.idx == ASP_FRAME_LAST) ? 5'h00 : f.idx + 5'h01;
        end
    end

    always_ff @(negedge link.dclk) begin
        f <= next_f;
    end

endmodule // asp_device

//--- rtl/asp_host.sv
// host end: AXI4-Lite registers driving the serial port
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module asp_host (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // write address and data
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // link to converter
    asp_link_if.host         link
);
    import asp_pkg::*;

    typedef struct packed {
        logic                    aw_got;
        logic [7:0]              waddr;
        logic                    w_got;
        logic [7:0]              wbyte;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [1:0]              rresp;
        logic [31:0]             rdata;
        logic [1:0]              chan;
        logic [ASP_PRESET_W-1:0] preset;
        logic [ASP_FRAME_W-1:0]  result;
        logic [1:0]              eoc_sync;
        logic [1:0]              dout_sync;
        asp_hstate_e             st;
        logic [7:0]              half;
        logic [4:0]              bits;
        logic [ASP_PRESET_W-1:0] sh;
        logic                    dclk;
        logic                    din;
        logic                    writing;
        logic                    start_wr;
        logic                    start_rd;
    } asp_host_s;

    asp_host_s r;
    asp_host_s next_r;
    logic      half_done;

    // bus handshakes
    assign awready = ~r.aw_got & ~r.bvalid;
    assign wready  = ~r.w_got & ~r.bvalid;
    assign bvalid  = r.bvalid;
    assign bresp   = r.bresp;
    assign arready = ~r.rvalid;
    assign rvalid  = r.rvalid;
    assign rresp   = r.rresp;
    assign rdata   = r.rdata;

    // link pins; rw idles high so reset leaves the port reading
    assign link.dclk               = r.dclk;
    assign link.din                = r.din;
    assign link.rw                 = ~r.writing;
    assign link.channel_select_lsb = r.chan[0];
    assign link.channel_select_msb = r.chan[1];

    assign half_done = (r.half == ASP_HALF_LAST);

    always_comb begin
        next_r           = r;
        next_r.eoc_sync  = {r.eoc_sync[0], link.eoc_n};
        next_r.dout_sync = {r.dout_sync[0], link.dout};
        next_r.start_wr  = 1'b0;
        next_r.start_rd  = 1'b0;
        // register writes, aw and w in either order
        if (awvalid && awready) begin
            next_r.aw_got = 1'b1;
            next_r.waddr  = awaddr;
        end
        if (wvalid && wready) begin
            next_r.w_got = 1'b1;
            next_r.wbyte = wstrb[0] ? wdata[7:0] : r.wbyte;
        end
        if (r.aw_got && r.w_got) begin
            next_r.aw_got = 1'b0;
            next_r.w_got  = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp  = ASP_RESP_OKAY;
            unique case (r.waddr)
                ASP_REG_CTRL: begin
                    next_r.chan     = r.wbyte[ASP_CTRL_CH_LO+1:ASP_CTRL_CH_LO];
                    next_r.start_wr = r.wbyte[ASP_CTRL_WRITE];
                    next_r.start_rd = r.wbyte[ASP_CTRL_READ];
                end
                ASP_REG_PRESET: next_r.preset = r.wbyte;
                ASP_REG_STATUS, ASP_REG_RESULT: ;
                default: next_r.bresp = ASP_RESP_SLVERR;
            endcase
        end
        if (r.bvalid && bready) begin
            next_r.bvalid = 1'b0;
        end
        // register reads
        if (arvalid && arready) begin
            next_r.rvalid = 1'b1;
            next_r.rresp  = ASP_RESP_OKAY;
            unique case (araddr)
                ASP_REG_CTRL:   next_r.rdata = {28'h0, r.chan, 2'h0};
                ASP_REG_PRESET: next_r.rdata = {24'h0, r.preset};
                ASP_REG_STATUS: next_r.rdata = {30'h0, r.eoc_sync[1], r.st != ASP_H_IDLE};
                ASP_REG_RESULT: next_r.rdata = {12'h000, r.result};
                default: begin
                    next_r.rdata = 32'h0;
                    next_r.rresp = ASP_RESP_SLVERR;
                end
            endcase
        end else if (r.rvalid && rready) begin
            next_r.rvalid = 1'b0;
        end
        // link sequencer; starts arriving while busy are dropped
        next_r.half = half_done ? 8'h00 : r.half + 8'h01;
        unique case (r.st)
            ASP_H_IDLE: begin
                next_r.half = 8'h00;
                next_r.bits = 5'h00;
                if (r.start_wr) begin
                    next_r.st = ASP_H_WAIT_EOC;
                end else if (r.start_rd) begin
                    next_r.st     = ASP_H_READ;
                    next_r.result = {r.dout_sync[1], 19'h0};
                end
            end
            ASP_H_WAIT_EOC: begin
                // writing outside auto-zero would upset the integrator
                next_r.half = 8'h00;
                if (!r.eoc_sync[1]) begin
                    next_r.st      = ASP_H_WRITE;
                    next_r.writing = 1'b1;
                    next_r.din     = r.preset[ASP_PRESET_W-1];
                    next_r.sh      = {r.preset[ASP_PRESET_W-2:0], 1'b0};
                end
            end
            ASP_H_WRITE: begin
                if (half_done) begin
                    if (r.dclk) begin
                        next_r.dclk = 1'b0;
                        next_r.bits = r.bits + 5'h01;
                        next_r.din  = r.sh[ASP_PRESET_W-1];
                        next_r.sh   = {r.sh[ASP_PRESET_W-2:0], 1'b0};
                    end else if (r.bits == ASP_WR_BITS) begin
                        next_r.writing = 1'b0;
                        next_r.din     = 1'b0;
                        next_r.st      = ASP_H_IDLE;
                    end else begin
                        next_r.dclk = 1'b1;
                    end
                end
            end
            ASP_H_READ: begin
                // twentieth fall wraps the device back to its eoc bit
                if (half_done) begin
                    if (r.dclk) begin
                        next_r.dclk = 1'b0;
                        next_r.bits = r.bits + 5'h01;
                    end else if (r.bits == ASP_RD_FALLS) begin
                        next_r.st = ASP_H_IDLE;
                    end else begin
                        if (r.bits != 5'h00) begin
                            next_r.result[ASP_FRAME_W-1-r.bits] = r.dout_sync[1];
                        end
                        next_r.dclk = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

endmodule // asp_host

//--- rtl/asp_link_if.sv
// serial link wires between host and converter
`timescale 1ns/1ps
interface asp_link_if;
    logic dclk;
    logic din;
    logic dout;
    logic rw;
    logic eoc_n;
    logic channel_select_lsb;
    logic channel_select_msb;
    modport device (input dclk, din, rw, channel_select_lsb, channel_select_msb,
                    output dout, eoc_n);
    modport host (output dclk, din, rw, channel_select_lsb, channel_select_msb,
                  input dout, eoc_n);
endinterface

//--- rtl/asp_pkg.sv
// constants and types for both ends of the serial port
// Summary of operation
// - device samples data-in on clock rising edge
// - device changes data-out on clock falling edge
// - host: direction high reads, low writes
// - read order: eoc, overrange, sign, magnitude msb-first
// - direction high: data-out shows eoc before clocking
// - host starts write only while eoc low
// - write moves 8-bit preset into input shifter
// - host ends write raising direction after 8 bits
// - direction rising: preset loads, conversion starts
// - host writes preset after reset before converting
// - two select lines pick channel, lsb first
// - oscillator divided by four gives timebase
// - reset input high holds auto-zero state
// - auto-zero and integrate durations equal, from preset
package asp_pkg;
    // link word sizes
    localparam int ASP_PRESET_W = 8;
    localparam int ASP_MAG_W    = 17;
    localparam int ASP_FRAME_W  = 20;
    // device timebase and phase counts
    localparam logic [1:0]  ASP_OSC_DIV_LAST = 2'h3;
    localparam logic [16:0] ASP_CNT_END      = 17'h0FFFF;
    localparam logic [16:0] ASP_DEINT_MAX    = 17'h1FFFF;
    localparam logic [16:0] ASP_IZ_LAST      = 17'h00003;
    localparam logic [7:0]  ASP_CNT_LOW      = 8'h00;
    localparam logic [4:0]  ASP_FRAME_LAST   = 5'h13;
    // host link timing: last aclk count of a half link clock, write bits, read falls
    localparam logic [7:0]  ASP_HALF_LAST    = 8'h07;
    localparam logic [4:0]  ASP_WR_BITS      = 5'h08;
    localparam logic [4:0]  ASP_RD_FALLS     = 5'h14;
    // host register map, byte addresses
    localparam logic [7:0]  ASP_REG_CTRL     = 8'h00;
    localparam logic [7:0]  ASP_REG_PRESET   = 8'h04;
    localparam logic [7:0]  ASP_REG_STATUS   = 8'h08;
    localparam logic [7:0]  ASP_REG_RESULT   = 8'h0C;
    // control field positions
    localparam int ASP_CTRL_WRITE = 0;
    localparam int ASP_CTRL_READ  = 1;
    localparam int ASP_CTRL_CH_LO = 2;
    // bus responses
    localparam logic [1:0]  ASP_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  ASP_RESP_SLVERR  = 2'h2;
    // converter phases
    typedef enum logic [1:0] {
        ASP_AUTO_ZERO_PHASE, ASP_INTEGRATE, ASP_DEINTEGRATE, ASP_INT_ZERO
    } asp_phase_e;
    // host sequencer states
    typedef enum logic [1:0] {
        ASP_H_IDLE, ASP_H_WAIT_EOC, ASP_H_WRITE, ASP_H_READ
    } asp_hstate_e;
endpackage
